/* src/scr_pkg.sv */
// Purpose: Shared constants and types of the speech codec control registers.
// Assumes: 250 MHz system clock, 20-bit registers, AHB-Lite word access.
// Notes:
// Functional notes
// - Output bit clock and frame strobe each invert when their polarity bit is 1.
// - Delay bit 1 shifts output data one bit period after the strobe edge.
// - Matrix code 00 halves the sum of both inputs, 01 right only, 10 left only; 11 forbidden.
// - Special option bit 0 set suppresses page headers; clear enables them.
// - Speed code 00 is 8 kHz, 01 is 6 kHz, 10 is 12 kHz; 11 forbidden.
// - Mute bit set silences the audio output while decoding runs; idle, encode and pause keep sending the last samples.
// - Pause bit set suspends encoding and decoding until cleared.
// - Mode code 00 idle, 01 decode, 11 encode; 10 forbidden.
package scr_pkg;

  // ----------------------------------------
  // Clock and rates
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned RATE_NORM_HZ = 8000;
  localparam int unsigned RATE_SLOW_HZ = 6000;
  localparam int unsigned RATE_FAST_HZ = 12000;
  localparam int unsigned BCLK_HALF_CYC = 4;
  localparam int unsigned SAMPLE_W = 20;
  localparam int unsigned FRAME_BITS = 40;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam int unsigned REG_W = 20;
  localparam logic [9:0] IDX_OUT_FMT = 10'h0E1;
  localparam logic [9:0] IDX_SPECIAL = 10'h0FA;
  localparam logic [9:0] IDX_GAIN = 10'h0FC;
  localparam logic [9:0] IDX_OP_SEL = 10'h0FD;
  localparam logic [11:0] ADDR_OUT_FMT = {IDX_OUT_FMT, 2'b00};
  localparam logic [11:0] ADDR_SPECIAL = {IDX_SPECIAL, 2'b00};
  localparam logic [11:0] ADDR_GAIN = {IDX_GAIN, 2'b00};
  localparam logic [11:0] ADDR_OP_SEL = {IDX_OP_SEL, 2'b00};

  // ----------------------------------------
  // Field positions, masks, reset values
  // ----------------------------------------
  localparam int unsigned FMT_BCLK_INV_BIT = 14;
  localparam int unsigned FMT_DELAY_BIT = 11;
  localparam int unsigned FMT_WS_INV_BIT = 5;
  localparam logic [19:0] FMT_MASK = 20'h04820;
  localparam int unsigned SPC_HDR_OFF_BIT = 0;
  localparam int unsigned SPC_MTX_LSB = 1;
  localparam logic [19:0] SPC_MASK = 20'h00007;
  localparam int unsigned OP_MODE_LSB = 0;
  localparam int unsigned OP_PAUSE_BIT = 2;
  localparam int unsigned OP_MUTE_BIT = 3;
  localparam int unsigned OP_SPEED_LSB = 4;
  localparam logic [19:0] OP_MASK = 20'h0003F;
  localparam logic [19:0] FMT_RESET = 20'h04000;
  localparam logic [19:0] SPC_RESET = 20'h00000;
  localparam logic [19:0] GAIN_RESET = 20'h7FFFF;
  localparam logic [19:0] OP_RESET = 20'h00000;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_DECODE = 2'b01,
    MODE_BAD = 2'b10,
    MODE_ENCODE = 2'b11
  } scr_mode_t;

  typedef enum logic [1:0] {
    SPD_NORM = 2'b00,
    SPD_SLOW = 2'b01,
    SPD_FAST = 2'b10,
    SPD_BAD = 2'b11
  } scr_speed_t;

  typedef enum logic [1:0] {
    MTX_SUM = 2'b00,
    MTX_RIGHT = 2'b01,
    MTX_LEFT = 2'b10,
    MTX_BAD = 2'b11
  } scr_matrix_t;

  typedef enum logic [2:0] {
    SEL_FMT = 3'b000,
    SEL_SPC = 3'b001,
    SEL_GAIN = 3'b010,
    SEL_OP = 3'b011,
    SEL_NONE = 3'b100
  } scr_sel_t;

endpackage : scr_pkg

/* src/scr_gain.sv */
// Purpose: Scale one output sample by the linear gain and apply mute.
// Assumes: Signed sample, unsigned gain with 0x7FFFF as just under unity.
// Notes: Result registered; updates only on load.
`timescale 1ns/1ps
module scr_gain (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic load_i,
  input wire logic mute_i,
  input wire logic [19:0] gain_i,
  // Data
  input wire logic signed [19:0] sample_i,
  output logic signed [19:0] sample_o
);

  logic signed [40:0] prod;

  // Gain is a fraction with 19 fraction bits, so 0x7FFFF scales the sample by just under one
  assign prod = sample_i * $signed({1'b0, gain_i});

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sample_o <= 20'sh00000;
    end
    else if (load_i)
    begin
      sample_o <= mute_i ? 20'sh00000 : prod[38:19];
    end
  end

endmodule : scr_gain

/* src/scr_regs.sv */
// Purpose: Control registers, sample pacing and serial audio output of the codec.
// Assumes: AHB-Lite single word transfers; pins synchronous to sys_clk_i.
// Notes: Zero wait states; forbidden field codes are ignored and the field keeps its value.
`timescale 1ns/1ps
module scr_regs #(
  parameter int unsigned PER_NORM = scr_pkg::CLK_HZ / scr_pkg::RATE_NORM_HZ,
  parameter int unsigned PER_SLOW = scr_pkg::CLK_HZ / scr_pkg::RATE_SLOW_HZ,
  parameter int unsigned PER_FAST = scr_pkg::CLK_HZ / scr_pkg::RATE_FAST_HZ
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Encoder input path
  input wire logic [19:0] enc_left_i,
  input wire logic [19:0] enc_right_i,
  output logic [19:0] enc_sample_o,
  output logic enc_valid_o,
  // Decoder output path
  input wire logic [19:0] dec_left_i,
  input wire logic [19:0] dec_right_i,
  output logic dec_req_o,
  // Status
  output logic header_enable_o,
  output logic run_decode_o,
  output logic run_encode_o,
  output logic paused_o,
  // Serial audio output
  output logic sod_o,
  output logic soi_o,
  output logic soc_o
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic scr_pkg::scr_sel_t decode_sel(input logic [31:0] addr);
    scr_pkg::scr_sel_t sel;
    sel = scr_pkg::SEL_NONE;
    if (addr[31:12] == 20'h00000)
    begin
      unique case (addr[11:0])
        scr_pkg::ADDR_OUT_FMT: sel = scr_pkg::SEL_FMT;
        scr_pkg::ADDR_SPECIAL: sel = scr_pkg::SEL_SPC;
        scr_pkg::ADDR_GAIN: sel = scr_pkg::SEL_GAIN;
        scr_pkg::ADDR_OP_SEL: sel = scr_pkg::SEL_OP;
        default: sel = scr_pkg::SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode_sel

  logic access;
  logic wr_pend_q;
  scr_pkg::scr_sel_t wr_sel_q;
  logic [19:0] fmt_q;
  logic [19:0] fmt_d;
  logic [19:0] spc_q;
  logic [19:0] spc_d;
  logic [19:0] gain_q;
  logic [19:0] gain_d;
  logic [19:0] op_q;
  logic [19:0] op_d;
  logic [19:0] wdata;
  logic [19:0] rd_val;
  logic [31:0] hrdata_q;

  // Only whole-word transfers are acted on; others complete without effect
  assign access = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'b010);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;
  assign wdata = hwdata_i[19:0];

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_pend_q <= 1'b0;
      wr_sel_q <= scr_pkg::SEL_NONE;
    end
    else
    begin
      wr_pend_q <= access && hwrite_i;
      wr_sel_q <= decode_sel(haddr_i);
    end
  end

  // ----------------------------------------
  // Register write with field checks
  // ----------------------------------------
  always_comb
  begin
    fmt_d = fmt_q;
    spc_d = spc_q;
    gain_d = gain_q;
    op_d = op_q;
    if (wr_pend_q)
    begin
      unique case (wr_sel_q)
        scr_pkg::SEL_FMT: fmt_d = wdata & scr_pkg::FMT_MASK;
        scr_pkg::SEL_SPC:
        begin
          spc_d = wdata & scr_pkg::SPC_MASK;
          if (wdata[scr_pkg::SPC_MTX_LSB +: 2] == scr_pkg::MTX_BAD)
          begin
            spc_d[scr_pkg::SPC_MTX_LSB +: 2] = spc_q[scr_pkg::SPC_MTX_LSB +: 2];
          end
        end
        scr_pkg::SEL_GAIN: gain_d = wdata;
        scr_pkg::SEL_OP:
        begin
          op_d = wdata & scr_pkg::OP_MASK;
          if (wdata[scr_pkg::OP_SPEED_LSB +: 2] == scr_pkg::SPD_BAD)
          begin
            op_d[scr_pkg::OP_SPEED_LSB +: 2] = op_q[scr_pkg::OP_SPEED_LSB +: 2];
          end
          if (wdata[scr_pkg::OP_MODE_LSB +: 2] == scr_pkg::MODE_BAD)
          begin
            op_d[scr_pkg::OP_MODE_LSB +: 2] = op_q[scr_pkg::OP_MODE_LSB +: 2];
          end
        end
        default:
        begin
          fmt_d = fmt_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      fmt_q <= scr_pkg::FMT_RESET;
      spc_q <= scr_pkg::SPC_RESET;
      gain_q <= scr_pkg::GAIN_RESET;
      op_q <= scr_pkg::OP_RESET;
    end
    else
    begin
      fmt_q <= fmt_d;
      spc_q <= spc_d;
      gain_q <= gain_d;
      op_q <= op_d;
    end
  end

  // Read from next values so a read right after a write sees the new data
  always_comb
  begin
    unique case (decode_sel(haddr_i))
      scr_pkg::SEL_FMT: rd_val = fmt_d;
      scr_pkg::SEL_SPC: rd_val = spc_d;
      scr_pkg::SEL_GAIN: rd_val = gain_d;
      scr_pkg::SEL_OP: rd_val = op_d;
      default: rd_val = 20'h00000;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      hrdata_q <= 32'h00000000;
    end
    else if (access && !hwrite_i)
    begin
      hrdata_q <= {12'h000, rd_val};
    end
  end

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  scr_pkg::scr_mode_t mode;
  scr_pkg::scr_speed_t speed;
  scr_pkg::scr_matrix_t matrix;
  logic pause;
  logic mute;
  logic active;

  assign mode = scr_pkg::scr_mode_t'(op_q[scr_pkg::OP_MODE_LSB +: 2]);
  assign speed = scr_pkg::scr_speed_t'(op_q[scr_pkg::OP_SPEED_LSB +: 2]);
  assign matrix = scr_pkg::scr_matrix_t'(spc_q[scr_pkg::SPC_MTX_LSB +: 2]);
  assign pause = op_q[scr_pkg::OP_PAUSE_BIT];
  assign mute = op_q[scr_pkg::OP_MUTE_BIT];
  assign active = (mode != scr_pkg::MODE_IDLE) && !pause;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      header_enable_o <= 1'b1;
      run_decode_o <= 1'b0;
      run_encode_o <= 1'b0;
      paused_o <= 1'b0;
    end
    else
    begin
      header_enable_o <= !spc_q[scr_pkg::SPC_HDR_OFF_BIT];
      run_decode_o <= (mode == scr_pkg::MODE_DECODE);
      run_encode_o <= (mode == scr_pkg::MODE_ENCODE);
      paused_o <= pause;
    end
  end

  // ----------------------------------------
  // Sample pacing
  // ----------------------------------------
  logic [19:0] per_cyc;
  logic [19:0] smp_cnt_q;
  logic tick;

  always_comb
  begin
    unique case (speed)
      scr_pkg::SPD_SLOW: per_cyc = 20'(PER_SLOW - 1);
      scr_pkg::SPD_FAST: per_cyc = 20'(PER_FAST - 1);
      default: per_cyc = 20'(PER_NORM - 1);
    endcase
  end

  assign tick = active && (smp_cnt_q == 20'h00000);

  // Counter freezes while paused so processing resumes in phase
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      smp_cnt_q <= 20'h00000;
    end
    else if (!active)
    begin
      smp_cnt_q <= smp_cnt_q;
    end
    else if (tick || smp_cnt_q > per_cyc)
    begin
      smp_cnt_q <= per_cyc;
    end
    else
    begin
      smp_cnt_q <= smp_cnt_q - 20'h00001;
    end
  end

  // ----------------------------------------
  // Encoder input matrixing
  // ----------------------------------------
  logic signed [20:0] mix_sum;

  // Sum halved so the mix cannot overflow the sample width
  assign mix_sum = $signed({enc_left_i[19], enc_left_i}) + $signed({enc_right_i[19], enc_right_i});

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      enc_sample_o <= 20'h00000;
      enc_valid_o <= 1'b0;
    end
    else
    begin
      enc_valid_o <= tick && (mode == scr_pkg::MODE_ENCODE);
      if (tick && (mode == scr_pkg::MODE_ENCODE))
      begin
        unique case (matrix)
          scr_pkg::MTX_RIGHT: enc_sample_o <= enc_right_i;
          scr_pkg::MTX_LEFT: enc_sample_o <= enc_left_i;
          default: enc_sample_o <= mix_sum[20:1];
        endcase
      end
    end
  end

  // ----------------------------------------
  // Decoder output scaling
  // ----------------------------------------
  logic dec_tick;
  logic [19:0] dec_in [2];
  logic [19:0] dec_out [2];

  assign dec_tick = tick && (mode == scr_pkg::MODE_DECODE);
  assign dec_req_o = dec_tick;
  assign dec_in[0] = dec_left_i;
  assign dec_in[1] = dec_right_i;

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    scr_gain u_gain (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(dec_tick),
      .mute_i(mute),
      .gain_i(gain_q),
      .sample_i(dec_in[ch]),
      .sample_o(dec_out[ch])
    );
  end

  // ----------------------------------------
  // Serial audio output
  // ----------------------------------------
  logic [2:0] div_q;
  logic half_en;
  logic phase_q;
  logic [5:0] bit_q;
  logic [39:0] frame_q;
  logic last_lsb_q;
  logic [5:0] pos;
  logic data_bit;

  assign half_en = (div_q == 3'(scr_pkg::BCLK_HALF_CYC - 1));

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      div_q <= 3'h0;
      phase_q <= 1'b0;
    end
    else
    begin
      div_q <= half_en ? 3'h0 : div_q + 3'h1;
      if (half_en)
      begin
        phase_q <= !phase_q;
      end
    end
  end

  // Data leaves on the falling edge of the standard clock, so the far end samples on rising
  assign pos = (bit_q == 6'h00) ? 6'(scr_pkg::FRAME_BITS - 1) : bit_q - 6'h01;
  assign data_bit = fmt_q[scr_pkg::FMT_DELAY_BIT] ?
    ((bit_q == 6'h00) ? last_lsb_q : frame_q[6'(scr_pkg::FRAME_BITS - 1) - pos]) :
    frame_q[6'(scr_pkg::FRAME_BITS - 1) - bit_q];

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      bit_q <= 6'h00;
      frame_q <= 40'h0000000000;
      last_lsb_q <= 1'b0;
    end
    else if (half_en && phase_q)
    begin
      if (bit_q == 6'(scr_pkg::FRAME_BITS - 1))
      begin
        bit_q <= 6'h00;
        frame_q <= {dec_out[0], dec_out[1]};
        last_lsb_q <= frame_q[0];
      end
      else
      begin
        bit_q <= bit_q + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sod_o <= 1'b0;
      soi_o <= 1'b0;
      soc_o <= 1'b0;
    end
    else
    begin
      soc_o <= phase_q ^ fmt_q[scr_pkg::FMT_BCLK_INV_BIT];
      sod_o <= data_bit;
      soi_o <= (bit_q >= 6'(scr_pkg::SAMPLE_W)) ^ fmt_q[scr_pkg::FMT_WS_INV_BIT];
    end
  end

endmodule : scr_regs

/* verification/scr_host.sv */
// Purpose: Host model that programs the control registers over AHB-Lite.
// Assumes: Single word transfers, one slave whose hreadyout is hready.
// Notes: Data lines show the inverse once a transfer is over.
`timescale 1ns/1ps
module scr_host (
  // Clock and slave answer
  input wire logic sys_clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  // Request
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  initial
  begin
    hsel_o = 1'b0;
    haddr_o = 32'h00000000;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h00000000;
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge sys_clk_i);
    hsel_o <= 1'b1;
    htrans_o <= 2'b10;
    haddr_o <= {20'h00000, a};
    hwrite_o <= w;
    do @(posedge sys_clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'b00;
    hwdata_o <= wd;
    do @(posedge sys_clk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
    hsel_o <= 1'b0;
    hwdata_o <= ~wd;
  endtask : xfer
endmodule : scr_host

/* verification/scr_checker.sv */
// Purpose: Port assertions of the control register block.
// Assumes: Bound to every scr_regs instance.
// Notes: Status outputs may lag a register write by one or two cycles.
`timescale 1ns/1ps
module scr_checker (
  // Clock, reset, bus
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Status
  input wire logic enc_valid_o,
  input wire logic dec_req_o,
  input wire logic header_enable_o,
  input wire logic run_decode_o,
  input wire logic run_encode_o,
  input wire logic paused_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence wr_to(a);
    hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'b010 && haddr_i == a;
  endsequence
  property hdr_p;
    logic v;
    wr_to({20'h0, scr_pkg::ADDR_SPECIAL}) ##1 (1, v = !hwdata_i[0])
      |-> ##[1:2] header_enable_o == v;
  endproperty
  property pause_p;
    logic v;
    wr_to({20'h0, scr_pkg::ADDR_OP_SEL}) ##1 (1, v = hwdata_i[2]) |-> ##[1:2] paused_o == v;
  endproperty

  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or okay");
  rdata_hi_a: assert property (hrdata_o[31:20] == 12'h000)
    else $error("read upper bits set");
  hdr_follow_a: assert property (hdr_p) else $error("header enable wrong");
  pause_follow_a: assert property (pause_p) else $error("pause flag wrong");
  // Request comes straight from the mode register; status flags trail it by one edge
  pause_frz_a: assert property (enc_valid_o || $past(dec_req_o) |-> !paused_o)
    else $error("sample while paused");
  dec_idle_a: assert property (dec_req_o |=> run_decode_o)
    else $error("decode request outside decode");
  enc_idle_a: assert property (!run_encode_o && !$past(run_encode_o) |-> !enc_valid_o)
    else $error("encode sample outside encode");
  modes_excl_a: assert property (!(run_decode_o && run_encode_o))
    else $error("two modes");
  req_gap_a: assert property (dec_req_o |=> !dec_req_o [*8])
    else $error("requests too close");
endmodule : scr_checker

bind scr_regs scr_checker i_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .enc_valid_o(enc_valid_o), .dec_req_o(dec_req_o),
  .header_enable_o(header_enable_o), .run_decode_o(run_decode_o),
  .run_encode_o(run_encode_o), .paused_o(paused_o));

/* verification/tb.sv */
// Purpose: Self-checking bench of the control register block.
// Assumes: Short pacing periods so that a run stays brief.
// Notes: Serial checks count ones over two frames or compare levels at a fixed phase of the free running frame.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("mismatch at %0t: %h vs %h", $time, (a), (b)); \
    end \
  end
module tb;
  localparam int PN = 40;
  localparam int PS = 53;
  localparam int PF = 26;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel, hwrite, hready, hresp, enc_valid, dec_req, hdr_en, run_dec, run_enc, paused;
  logic sod, soi, soc;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [19:0] enc_l = 20'h00000, enc_r = 20'h00000, dec_l = 20'h00000, dec_r = 20'h00000;
  logic [19:0] enc_smp;
  int failures = 0, checks = 0, seed = 32'h74D6, cyc = 0;
  int per[3] = '{PN, PS, PF};

  initial forever #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    dec_l <= 20'($random(seed));
    dec_r <= 20'($random(seed));
  end

  scr_regs #(.PER_NORM(PN), .PER_SLOW(PS), .PER_FAST(PF)) i_scr_regs (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .enc_left_i(enc_l), .enc_right_i(enc_r),
    .enc_sample_o(enc_smp), .enc_valid_o(enc_valid), .dec_left_i(dec_l), .dec_right_i(dec_r),
    .dec_req_o(dec_req), .header_enable_o(hdr_en), .run_decode_o(run_dec),
    .run_encode_o(run_enc), .paused_o(paused), .sod_o(sod), .soi_o(soi), .soc_o(soc));
  scr_host u_host (.sys_clk_i(sys_clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  task automatic wr(input logic [11:0] a, input logic [19:0] d);
    u_host.xfer(1'b1, a, {12'h000, d}, rd);
  endtask : wr
  task automatic ck_rd(input logic [11:0] a, input logic [19:0] e);
    u_host.xfer(1'b0, a, 32'h00000000, rd);
    `CHK(rd, {12'h000, e})
  endtask : ck_rd
  function automatic logic [19:0] mtx(input logic [1:0] m, input logic [19:0] l,
                                      input logic [19:0] r);
    logic signed [20:0] s;
    s = $signed({l[19], l}) + $signed({r[19], r});
    case (m)
      2'b01: return r;
      2'b10: return l;
      default: return s[20:1];
    endcase
  endfunction : mtx
  // Cycles between two decode requests
  task automatic gap(output int n);
    n = 0;
    while (dec_req !== 1'b1 && n < 300)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge sys_clk_i);
      n++;
    end while (dec_req !== 1'b1 && n < 300);
  endtask : gap
  task automatic ones(output int n);
    n = 0;
    repeat (400) @(negedge sys_clk_i);
    repeat (640)
    begin
      @(negedge sys_clk_i);
      n += int'(sod !== 1'b0);
    end
  endtask : ones
  task automatic phase;
    do @(negedge sys_clk_i); while (cyc % 320 != 100);
  endtask : phase
  // One sample per bit period over a whole frame, first bit in the top position
  task automatic cap(output logic [39:0] b);
    b = 40'h0000000000;
    repeat (40)
    begin
      b = {b[38:0], sod};
      repeat (8) @(negedge sys_clk_i);
    end
  endtask : cap
  task summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    #200000;
    failures++;
    summarize();
  end

  initial
  begin
    logic [19:0] v;
    logic [1:0] s0;
    logic [39:0] b0, b1;
    int n;
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    ck_rd(scr_pkg::ADDR_OUT_FMT, 20'h04000);
    ck_rd(scr_pkg::ADDR_SPECIAL, 20'h00000);
    ck_rd(scr_pkg::ADDR_GAIN, 20'h7FFFF);
    ck_rd(scr_pkg::ADDR_OP_SEL, 20'h00000);
    ck_rd(12'h3EC, 20'h00000);
    for (int i = 0; i < 6; i++)
    begin
      v = 20'($random(seed)) & scr_pkg::FMT_MASK;
      wr(scr_pkg::ADDR_OUT_FMT, v);
      ck_rd(scr_pkg::ADDR_OUT_FMT, v);
      v = 20'($random(seed));
      wr(scr_pkg::ADDR_GAIN, v);
      ck_rd(scr_pkg::ADDR_GAIN, v);
      v = 20'($random(seed)) & 20'h00003;
      wr(scr_pkg::ADDR_SPECIAL, v);
      ck_rd(scr_pkg::ADDR_SPECIAL, v);
      `CHK(hdr_en, ~v[0])
    end
    // Forbidden codes leave their field alone
    wr(scr_pkg::ADDR_OP_SEL, 20'h0001C);
    wr(scr_pkg::ADDR_OP_SEL, 20'h00032);
    ck_rd(scr_pkg::ADDR_OP_SEL, 20'h00010);
    wr(scr_pkg::ADDR_SPECIAL, 20'h00002);
    wr(scr_pkg::ADDR_SPECIAL, 20'h00007);
    ck_rd(scr_pkg::ADDR_SPECIAL, 20'h00003);
    wr(scr_pkg::ADDR_OP_SEL, 20'h00000);
    for (int m = 0; m < 3; m++)
    begin
      enc_l <= 20'($random(seed));
      enc_r <= 20'($random(seed));
      wr(scr_pkg::ADDR_SPECIAL, {17'h00000, m[1:0], 1'b0});
      wr(scr_pkg::ADDR_OP_SEL, 20'h00003);
      n = 0;
      while (enc_valid !== 1'b1 && n < 300)
      begin
        @(negedge sys_clk_i);
        n++;
      end
      `CHK(enc_valid, 1'b1)
      `CHK(enc_smp, mtx(m[1:0], enc_l, enc_r))
      `CHK(run_enc, 1'b1)
      wr(scr_pkg::ADDR_OP_SEL, 20'h00000);
    end
    for (int s = 0; s < 3; s++)
    begin
      repeat (8) @(posedge sys_clk_i);
      wr(scr_pkg::ADDR_OP_SEL, {14'h0000, s[1:0], 4'h1});
      gap(n);
      `CHK(n, per[s])
      `CHK(run_dec, 1'b1)
      wr(scr_pkg::ADDR_OP_SEL, 20'h00000);
    end
    wr(scr_pkg::ADDR_OP_SEL, 20'h00005);
    n = 0;
    repeat (100)
    begin
      @(negedge sys_clk_i);
      n += int'(dec_req !== 1'b0);
    end
    `CHK(n, 0)
    `CHK(paused, 1'b1)
    wr(scr_pkg::ADDR_OP_SEL, 20'h00001);
    gap(n);
    `CHK(n, PN)
    // Audio at the serial output: present, muted, then zero gain
    wr(scr_pkg::ADDR_OUT_FMT, 20'h00000);
    wr(scr_pkg::ADDR_GAIN, 20'h7FFFF);
    ones(n);
    `CHK(n != 0, 1'b1)
    wr(scr_pkg::ADDR_OP_SEL, 20'h00009);
    ones(n);
    `CHK(n, 0)
    wr(scr_pkg::ADDR_OP_SEL, 20'h00001);
    wr(scr_pkg::ADDR_GAIN, 20'h00000);
    ones(n);
    `CHK(n, 0)
    phase();
    s0 = {soc, soi};
    wr(scr_pkg::ADDR_OUT_FMT, 20'h04020);
    phase();
    `CHK({soc, soi}, ~s0)
    // Idle freezes the frame, so the delayed capture is the plain one rotated by one bit
    wr(scr_pkg::ADDR_GAIN, 20'h7FFFF);
    repeat (2 * PN) @(negedge sys_clk_i);
    wr(scr_pkg::ADDR_OP_SEL, 20'h00000);
    phase();
    phase();
    cap(b0);
    wr(scr_pkg::ADDR_OUT_FMT, 20'h04820);
    phase();
    cap(b1);
    `CHK(b1, {b0[0], b0[39:1]})
    summarize();
  end
endmodule : tb
